// File: psr_pkg.sv
// Shared layout of the processor status word
package psr_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam logic [11:0] STATUS_OFS = 12'h000;
  // Fields common to both layouts
  localparam int CU_LSB = 28;
  localparam int IM_LSB = 8;
  localparam int BEV_BIT = 22;
  localparam int TS_BIT = 21;
  // Layout A stack and cache diagnostics
  localparam int A_PE_BIT = 20;
  localparam int A_CM_BIT = 19;
  localparam int A_PZ_BIT = 18;
  localparam int A_SWC_BIT = 17;
  localparam int A_ISC_BIT = 16;
  localparam int A_KUO_BIT = 5;
  localparam int A_KUC_BIT = 1;
  localparam int A_IEC_BIT = 0;
  // Layout B mode, addressing and cache bits
  localparam int B_RP_BIT = 27;
  localparam int B_FR_BIT = 26;
  localparam int B_RE_BIT = 25;
  localparam int B_SRF_BIT = 20;
  localparam int B_CH_BIT = 18;
  localparam int B_CHK_BIT = 17;
  localparam int B_DE_BIT = 16;
  localparam int B_KX_BIT = 7;
  localparam int B_SX_BIT = 6;
  localparam int B_UX_BIT = 5;
  localparam int B_KSU_LSB = 3;
  localparam int B_ERL_BIT = 2;
  localparam int B_EXL_BIT = 1;
  localparam int B_IE_BIT = 0;
  // Privilege encodings
  localparam logic [1:0] KSU_KERNEL = 2'h0;
  localparam logic [1:0] KSU_SUPER = 2'h1;
  localparam logic [1:0] KSU_USER = 2'h2;
  // Implemented bits; everything else reads zero
  localparam logic [31:0] A_IMPL_MASK = 32'hF07F_FF3F;
  localparam logic [31:0] B_IMPL_MASK = 32'hFE77_FFFF;
  // Bits software writes as plain storage
  localparam logic [31:0] A_WR_MASK = 32'hF06F_FF3F;
  localparam logic [31:0] B_WR_MASK = 32'hFE57_FFFF;
  // Reset values: bootstrap vectors, kernel, interrupts off
  localparam logic [31:0] A_RESET = 32'h0040_0000;
  localparam logic [31:0] B_RESET = 32'h0040_0004;
endpackage

// File: psr_apb_port.sv
`timescale 1ns/100ps
// Zero-wait APB slave for the single status word
module psr_apb_port #(
  parameter int ADDR_W = psr_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] rd_word,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_en
);
  // Address decode
  wire hit = (paddr == ADDR_W'(psr_pkg::STATUS_OFS));
  wire setup = psel && !penable;
  wire access = psel && penable;
  // Read word chosen during setup
  wire [31:0] next_prdata = (setup && !pwrite && hit) ? rd_word : 32'h0000_0000;

  // Always ready: access phase lasts one cycle
  assign pready = access;
  // Unmapped address answers with an error
  assign pslverr = access && !hit;
  // Write takes effect at the access edge only
  assign wr_en = access && pwrite && hit;

  // Read data captured at setup so it sits in a flop during access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= next_prdata;
    end
  end
endmodule // psr_apb_port

// File: psr_status.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - 32-bit status word, software read and write
// - Layout A: three-level mode/enable stack, direct access
// - Exception pushes stack: old=prev, prev=current
// - Exception return pops: current=prev, prev=old
// - Four coprocessor usable bits, one each
// - Coprocessor zero usable in kernel mode always
// - Interrupt raised when enabled, masked and pending
// - Boot-vector bit selects bootstrap exception vectors
// - Hardware sets TLB shutdown; read-only in B
// - Layout A parity flag; write one clears
// - Test miss flag records hit or miss
// - Parity-zero bit forces cache parity to zero
// - Swap exchanges caches; isolate cuts cache off
// - Reserved bits read zero, writes ignored
// - Layout B privilege: 10 user, 01 super, 00 kernel
// - Error and exception level bits show state
// - Reduced-power bit lowers internal clock rate
// - Float register bit: 16 or 32 registers
// - Endian reversal applies to user-mode accesses
// - Per-mode wide addressing; super/user also wide ops
// - Check-enable uses ECC word; disable suppresses errors
module psr_status #(
  parameter bit VARIANT_B = 1'b0, // Layout select
  parameter int ADDR_W = psr_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic arst_n,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core events, same clock, one-cycle pulses; irq_pending is a level
  input wire logic exc_take,
  input wire logic err_take,
  input wire logic exception_return_instr,
  input wire logic tlb_shutdown_evt,
  input wire logic parity_err_evt,
  input wire logic soft_restart_evt,
  input wire logic test_miss_valid,
  input wire logic test_miss,
  input wire logic sec_hit_valid,
  input wire logic sec_hit,
  input wire logic [7:0] irq_pending,
  // Control outputs to the core
  output logic irq_req,
  output logic [3:0] coproc_usable,
  output logic boot_vector_sel,
  output logic kernel_mode,
  output logic super_mode,
  output logic user_mode,
  output logic parity_zero_force,
  output logic cache_swap,
  output logic cache_isolate,
  output logic low_power_clock,
  output logic float_reg_count_sel,
  output logic byte_swap_user_mode,
  output logic wide_addr_active,
  output logic wide_ops_active,
  output logic ecc_check_en,
  output logic error_exc_disable
);
  // Layout-dependent constants
  localparam logic [31:0] IMPL_MASK = VARIANT_B ? psr_pkg::B_IMPL_MASK : psr_pkg::A_IMPL_MASK;
  localparam logic [31:0] WR_MASK = VARIANT_B ? psr_pkg::B_WR_MASK : psr_pkg::A_WR_MASK;
  localparam logic [31:0] RESET_VAL = VARIANT_B ? psr_pkg::B_RESET : psr_pkg::A_RESET;

  logic [31:0] stat; // The status word itself
  logic [31:0] next_stat; // Value for the next edge
  logic wr_en; // Accepted register write

  // Bus slave; read returns the live word
  psr_apb_port #(
    .ADDR_W(ADDR_W)
  ) u_port (
    .clk(clk),
    .arst_n(arst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rd_word(stat),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_en(wr_en)
  );

  // Named fields of the stored word
  wire [3:0] cu_bits = stat[psr_pkg::CU_LSB +: 4];
  wire [7:0] im_bits = stat[psr_pkg::IM_LSB +: 8];
  wire [1:0] privilege_level = stat[psr_pkg::B_KSU_LSB +: 2];
  wire error_level = stat[psr_pkg::B_ERL_BIT];
  wire exception_level = stat[psr_pkg::B_EXL_BIT];
  // Plain write merge; hardware-owned bits kept
  wire [31:0] wr_merge = (stat & ~WR_MASK) | (pwdata & WR_MASK);

  // Mode decode; in B an exception or error level forces kernel
  wire a_kernel = !stat[psr_pkg::A_KUC_BIT];
  wire b_kernel = (privilege_level == psr_pkg::KSU_KERNEL) || exception_level || error_level;
  wire b_super = (privilege_level == psr_pkg::KSU_SUPER) && !exception_level && !error_level;
  wire b_user = (privilege_level == psr_pkg::KSU_USER) && !exception_level && !error_level;
  // Global interrupt enable as seen by the core
  wire irq_enabled = VARIANT_B ? (stat[psr_pkg::B_IE_BIT] && !exception_level && !error_level)
                               : stat[psr_pkg::A_IEC_BIT];

  // Next value: software first, then hardware events on top
  always_comb begin
    next_stat = stat;
    if (wr_en) begin
      next_stat = wr_merge;
      // Write one clears the parity flag
      if (!VARIANT_B && pwdata[psr_pkg::A_PE_BIT]) begin
        next_stat[psr_pkg::A_PE_BIT] = 1'b0;
      end
    end
    // TLB shutdown sets regardless of any write
    if (tlb_shutdown_evt) begin
      next_stat[psr_pkg::TS_BIT] = 1'b1;
    end
    if (!VARIANT_B) begin
      // Push beats pop if both arrive
      if (exc_take) begin
        // Current becomes kernel, interrupts off
        next_stat[psr_pkg::A_KUO_BIT:0] = {next_stat[3:0], 2'h0};
      end else if (exception_return_instr) begin
        // Old level left as it was
        next_stat[3:0] = next_stat[psr_pkg::A_KUO_BIT:2];
      end
      // Event set wins over a write-one clear
      if (parity_err_evt) begin
        next_stat[psr_pkg::A_PE_BIT] = 1'b1;
      end
      if (test_miss_valid) begin
        next_stat[psr_pkg::A_CM_BIT] = test_miss;
      end
    end else begin
      // Error level outranks exception level
      if (err_take) begin
        next_stat[psr_pkg::B_ERL_BIT] = 1'b1;
      end
      if (exc_take) begin
        next_stat[psr_pkg::B_EXL_BIT] = 1'b1;
      end
      // Return clears the innermost level only
      if (exception_return_instr && !err_take && !exc_take) begin
        if (error_level) begin
          next_stat[psr_pkg::B_ERL_BIT] = 1'b0;
        end else begin
          next_stat[psr_pkg::B_EXL_BIT] = 1'b0;
        end
      end
      if (soft_restart_evt) begin
        next_stat[psr_pkg::B_SRF_BIT] = 1'b1;
      end
      if (sec_hit_valid) begin
        next_stat[psr_pkg::B_CH_BIT] = sec_hit;
      end
    end
    // Unimplemented positions never hold a one
    next_stat = next_stat & IMPL_MASK;
  end

  // Status word storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat <= RESET_VAL;
    end else begin
      stat <= next_stat;
    end
  end

  // Interrupt request to the core, level
  assign irq_req = irq_enabled && |(im_bits & irq_pending);

  // Coprocessor zero always usable in kernel
  assign coproc_usable = {cu_bits[3:1], cu_bits[0] | kernel_mode};
  assign boot_vector_sel = stat[psr_pkg::BEV_BIT];

  // Mode outputs for both layouts
  assign kernel_mode = VARIANT_B ? b_kernel : a_kernel;
  assign super_mode = VARIANT_B ? b_super : 1'b0;
  assign user_mode = VARIANT_B ? b_user : !a_kernel;

  // Layout A cache diagnostics; tied low in B
  assign parity_zero_force = !VARIANT_B && stat[psr_pkg::A_PZ_BIT];
  assign cache_swap = !VARIANT_B && stat[psr_pkg::A_SWC_BIT];
  assign cache_isolate = !VARIANT_B && stat[psr_pkg::A_ISC_BIT];

  // Layout B controls; tied low in A
  assign low_power_clock = VARIANT_B && stat[psr_pkg::B_RP_BIT];
  assign float_reg_count_sel = VARIANT_B && stat[psr_pkg::B_FR_BIT];
  // Byte reversal matters only while running in user mode
  assign byte_swap_user_mode = VARIANT_B && stat[psr_pkg::B_RE_BIT] && b_user;
  // Wide addressing follows the mode in force
  assign wide_addr_active = VARIANT_B && ((b_kernel && stat[psr_pkg::B_KX_BIT])
                                         || (b_super && stat[psr_pkg::B_SX_BIT])
                                         || (b_user && stat[psr_pkg::B_UX_BIT]));
  // Kernel wide ops not granted by the kernel bit
  assign wide_ops_active = VARIANT_B && ((b_super && stat[psr_pkg::B_SX_BIT])
                                        || (b_user && stat[psr_pkg::B_UX_BIT]));
  assign ecc_check_en = VARIANT_B && stat[psr_pkg::B_CHK_BIT];
  assign error_exc_disable = VARIANT_B && stat[psr_pkg::B_DE_BIT];

  // Checks on the stored word and derived controls
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Push shifts the stack up by one level
  a_push_stack: assert property (!VARIANT_B && exc_take && !wr_en |=>
    stat[5:0] == {$past(stat[3:0]), 2'h0}) else $error("stack push wrong");

  // Pop shifts down and keeps the old level
  a_pop_stack: assert property (!VARIANT_B && exception_return_instr && !exc_take && !wr_en
    |=> stat[3:0] == $past(stat[5:2]) && stat[5:4] == $past(stat[5:4]))
    else $error("stack pop wrong");

  // Push always lands in kernel with interrupts off
  a_push_kernel: assert property (!VARIANT_B && exc_take |=>
    kernel_mode && !irq_req) else $error("push left user or irq on");

  // No request without enable, mask and pending
  a_irq_gate: assert property (irq_req |-> irq_enabled && |(irq_pending &
    stat[15:8])) else $error("irq without enable and mask");

  // Positions outside the layout stay zero
  a_rsvd_zero: assert property ((stat & ~IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bit set");

  // Coprocessor zero follows kernel mode
  a_cop0_kernel: assert property (kernel_mode |-> coproc_usable[0])
    else $error("cop0 unusable in kernel");

  // Parity event never lost, even against a clear
  a_parity_sticky: assert property (!VARIANT_B && parity_err_evt |=>
    stat[psr_pkg::A_PE_BIT]) else $error("parity flag lost");

  // Layout B shutdown flag only rises by hardware
  a_ts_readonly: assert property (VARIANT_B && !stat[psr_pkg::TS_BIT] && !tlb_shutdown_evt
    |=> !stat[psr_pkg::TS_BIT]) else $error("shutdown flag written");

  // Exception level set on every B exception
  a_exl_set: assert property (VARIANT_B && exc_take |=> stat[psr_pkg::B_EXL_BIT]
    && kernel_mode) else $error("exception level not set");

  // User decode and byte reversal agree
  a_user_decode: assert property (user_mode && VARIANT_B |->
    privilege_level == psr_pkg::KSU_USER && !byte_swap_user_mode == !stat[psr_pkg::B_RE_BIT])
    else $error("user decode wrong");

  // Plain write lands in the mask field
  a_write_store: assert property (wr_en && !exc_take && !exception_return_instr
    && !err_take |=> stat[15:8] == $past(pwdata[15:8]))
    else $error("mask not stored");

  // Access phase never waits
  a_access_ready: assert property (psel && penable |-> pready)
    else $error("access not ready");

  // Read word is the word stored at setup
  a_read_word: assert property (psel && !penable && !pwrite
    && paddr == ADDR_W'(psr_pkg::STATUS_OFS) |=> prdata == $past(stat))
    else $error("read word wrong");

  // Other addresses answer with an error and store nothing
  a_unmapped_err: assert property (psel && penable
    && paddr != ADDR_W'(psr_pkg::STATUS_OFS) |-> pslverr && !wr_en)
    else $error("unmapped access accepted");

  // Write one clears parity flag when no event competes
  a_parity_clear: assert property (!VARIANT_B && wr_en
    && pwdata[psr_pkg::A_PE_BIT] && !parity_err_evt |=> !stat[psr_pkg::A_PE_BIT])
    else $error("parity flag not cleared");

  // Shutdown event always shows in the word
  a_ts_set: assert property (tlb_shutdown_evt |=> stat[psr_pkg::TS_BIT])
    else $error("shutdown flag not set");

  // Test miss flag records the reported outcome
  a_miss_record: assert property (!VARIANT_B && test_miss_valid
    |=> stat[psr_pkg::A_CM_BIT] == $past(test_miss)) else $error("miss flag wrong");

  // Secondary hit flag records the reported outcome
  a_hit_record: assert property (VARIANT_B && sec_hit_valid
    |=> stat[psr_pkg::B_CH_BIT] == $past(sec_hit)) else $error("hit flag wrong");

  // Error level forces kernel
  a_erl_set: assert property (VARIANT_B && err_take |=>
    stat[psr_pkg::B_ERL_BIT] && kernel_mode) else $error("error level not set");

  // Return peels the error level before the exception level
  a_return_order: assert property (VARIANT_B && exception_return_instr && error_level
    && !err_take && !exc_take && !wr_en
    |=> !stat[psr_pkg::B_ERL_BIT] && stat[psr_pkg::B_EXL_BIT] == $past(exception_level))
    else $error("return order wrong");

  // Layout A has exactly one of kernel and user
  a_mode_a: assert property (!VARIANT_B |->
    kernel_mode != user_mode && !super_mode) else $error("layout A mode wrong");

  // Fields of the other layout stay low
  a_layout_a_only: assert property (!VARIANT_B |-> !low_power_clock
    && !float_reg_count_sel && !byte_swap_user_mode && !ecc_check_en && !error_exc_disable)
    else $error("B control in layout A");
  a_layout_b_only: assert property (VARIANT_B |-> !parity_zero_force
    && !cache_swap && !cache_isolate) else $error("A control in layout B");

  // Kernel wide addressing follows its own bit, never wide ops
  a_wide_kernel: assert property (VARIANT_B && kernel_mode |->
    wide_addr_active == stat[psr_pkg::B_KX_BIT] && !wide_ops_active)
    else $error("kernel wide mode wrong");

  // Supervisor gets wide addressing and ops from one bit
  a_wide_super: assert property (VARIANT_B && super_mode |->
    wide_addr_active == stat[psr_pkg::B_SX_BIT] && wide_ops_active == stat[psr_pkg::B_SX_BIT])
    else $error("super wide mode wrong");

  // Reversal never leaks outside user mode
  a_swap_user: assert property (!user_mode |-> !byte_swap_user_mode)
    else $error("reversal outside user mode");

  // Upper coprocessor bits follow the field directly
  a_cu_upper: assert property (coproc_usable[3:1] == stat[31:29])
    else $error("coprocessor bits wrong");

  // Vector select follows the stored bit
  a_boot_vector: assert property (boot_vector_sel == stat[psr_pkg::BEV_BIT])
    else $error("vector select wrong");

  // Main scenarios worth seeing
  c_push_pop: cover property (exc_take ##[1:20] exception_return_instr);
  c_irq_raised: cover property (irq_req);
  c_sw_write: cover property (wr_en ##1 psel && penable && !pwrite);
  c_parity_clear: cover property (!VARIANT_B && stat[psr_pkg::A_PE_BIT] ##1
    !stat[psr_pkg::A_PE_BIT]);
  c_user_kernel: cover property (user_mode ##1 kernel_mode);
endmodule // psr_status

// File: psr_core_model.sv
`timescale 1ns/100ps
// Core-side stand-in: one-cycle event pulses and a pending level
module psr_core_model (
  input wire logic clk,
  output logic exc_take,
  output logic err_take,
  output logic exception_return_instr,
  output logic tlb_shutdown_evt,
  output logic parity_err_evt,
  output logic soft_restart_evt,
  output logic test_miss_valid,
  output logic test_miss,
  output logic sec_hit_valid,
  output logic sec_hit,
  output logic [7:0] irq_pending
);
  logic [7:0] evt = 8'h00; // One bit per event line
  logic flag = 1'b0; // Hit or miss outcome for both recorders
  logic [7:0] pend = 8'h00; // Cause-side pending level
  assign {sec_hit_valid, test_miss_valid, soft_restart_evt, parity_err_evt} = evt[7:4];
  assign {tlb_shutdown_evt, exception_return_instr, err_take, exc_take} = evt[3:0];
  assign test_miss = flag;
  assign sec_hit = flag;
  assign irq_pending = pend;
  // Exactly one cycle high, so a stuck event never double-pushes the stack
  task automatic fire(input int k, input logic f);
    @(posedge clk);
    evt[k] <= 1'h1;
    flag <= f;
    @(posedge clk);
    evt <= 8'h00;
  endtask
endmodule // psr_core_model

// File: test_processor_status_register.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module test_processor_status_register;
  logic clk = 1'h0; // 125 MHz clock
  logic arst_n = 1'h0; // Held low at start
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // APB request
  logic [psr_pkg::ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  int failures = 0, checks = 0;
  logic [31:0] rd [2]; // Read data taken per layout
  logic [1:0] err; // Error response taken per layout
  logic [31:0] prdata [2];
  logic [3:0] cu [2];
  logic [1:0] pready, pslverr, irq, bvs, km, sm, um, pzf, csw, cis, lpc, frs, bsu, waa, woa;
  logic [1:0] ece, eed;
  logic exc, errt, ret, tlb, par, srst, tmv, tm, shv, sh;
  logic [7:0] pend;
  psr_core_model core (.clk(clk), .exc_take(exc), .err_take(errt), .exception_return_instr(ret),
    .tlb_shutdown_evt(tlb), .parity_err_evt(par), .soft_restart_evt(srst),
    .test_miss_valid(tmv), .test_miss(tm), .sec_hit_valid(shv), .sec_hit(sh), .irq_pending(pend));
  // Both layouts side by side, fed the same bus and events
  for (genvar g = 0; g < 2; g++) begin : gen_v
    psr_status #(.VARIANT_B(g == 1), .ADDR_W(psr_pkg::ADDR_W)) uut (.clk(clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata[g]), .pready(pready[g]), .pslverr(pslverr[g]), .exc_take(exc),
      .err_take(errt), .exception_return_instr(ret), .tlb_shutdown_evt(tlb),
      .parity_err_evt(par), .soft_restart_evt(srst), .test_miss_valid(tmv), .test_miss(tm),
      .sec_hit_valid(shv), .sec_hit(sh), .irq_pending(pend), .irq_req(irq[g]),
      .coproc_usable(cu[g]), .boot_vector_sel(bvs[g]), .kernel_mode(km[g]),
      .super_mode(sm[g]), .user_mode(um[g]), .parity_zero_force(pzf[g]), .cache_swap(csw[g]),
      .cache_isolate(cis[g]), .low_power_clock(lpc[g]), .float_reg_count_sel(frs[g]),
      .byte_swap_user_mode(bsu[g]), .wide_addr_active(waa[g]), .wide_ops_active(woa[g]),
      .ecc_check_en(ece[g]), .error_exc_disable(eed[g]));
  end
  initial begin
    forever #4 clk = ~clk;
  end
  // One APB transfer; waits on pready, never assumes a latency
  task automatic apb(input logic w, input logic [psr_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 2'h3 && n < 20);
    `CHK("pready", 2'h3, pready)
    rd[0] = prdata[0];
    rd[1] = prdata[1];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input string n, input logic [31:0] ea, input logic [31:0] eb);
    apb(1'h0, psr_pkg::STATUS_OFS, 32'h0000_0000);
    `CHK(n, ea, rd[0])
    `CHK(n, eb, rd[1])
  endtask
  task automatic t_reset;
    rdchk("reset", psr_pkg::A_RESET, psr_pkg::B_RESET);
    `CHK("bev", 2'h3, bvs)
  endtask
  task automatic t_rw;
    apb(1'h1, 12'h000, 32'hFFFF_FFFF);
    rdchk("ones", psr_pkg::A_WR_MASK, psr_pkg::B_WR_MASK);
    `CHK("diag_a", 3'h7, {pzf[0], csw[0], cis[0]})
    `CHK("diag_b", 4'hF, {lpc[1], frs[1], ece[1], eed[1]})
    `CHK("layout", 7'h00, {pzf[1], csw[1], cis[1], lpc[0], frs[0], ece[0], eed[0]})
    apb(1'h1, 12'h000, 32'h0000_0000);
    rdchk("zeros", 32'h0000_0000, 32'h0000_0000);
    `CHK("diag_off", 7'h00, {pzf[0], csw[0], cis[0], lpc[1], frs[1], ece[1], eed[1]})
  endtask
  // Unmapped place answers with an error and leaves the word alone
  task automatic t_unmapped;
    apb(1'h1, 12'h004, 32'hFFFF_FFFF);
    `CHK("err_w", 2'h3, err)
    apb(1'h0, 12'h004, 32'h0000_0000);
    `CHK("rd_un", 33'h0_0000_0000, {err != 2'h3, rd[0] | rd[1]})
    rdchk("kept", 32'h0000_0000, 32'h0000_0000);
  endtask
  // Two pushes then one pop; old level must survive the pop
  task automatic t_stack;
    apb(1'h1, 12'h000, 32'h0000_0003);
    core.fire(0, 1'h0);
    rdchk("push1", 32'h0000_000C, 32'h0000_0003);
    core.fire(0, 1'h0);
    rdchk("push2", 32'h0000_0030, 32'h0000_0003);
    core.fire(2, 1'h0);
    rdchk("pop", 32'h0000_003C, 32'h0000_0001);
    apb(1'h1, 12'h000, 32'h0000_0000);
    core.fire(1, 1'h0);
    rdchk("err_lvl", 32'h0000_0000, 32'h0000_0004);
    `CHK("kern", 2'h3, km)
  endtask
  task automatic t_irq;
    core.pend <= 8'h80;
    apb(1'h1, 12'h000, 32'h0000_8001);
    @(posedge clk);
    `CHK("irq_on", 2'h3, irq)
    core.pend <= 8'h40;
    @(posedge clk);
    `CHK("irq_mask", 2'h0, irq)
    core.pend <= 8'h80;
    apb(1'h1, 12'h000, 32'h0000_8000);
    @(posedge clk);
    `CHK("irq_off", 2'h0, irq)
  endtask
  task automatic t_mode;
    apb(1'h1, 12'h000, 32'h0000_0012);
    @(posedge clk);
    `CHK("cu_user", 8'h01, {cu[0], cu[1]})
    `CHK("a_user", 3'h2, {km[0], um[0], sm[0]})
    apb(1'h1, 12'h000, 32'hE200_0030);
    @(posedge clk);
    `CHK("cu_kern", 8'hFE, {cu[0], cu[1]})
    `CHK("b_user", 5'h1F, {um[1], bsu[1], waa[1], woa[1], ~km[1]})
    apb(1'h1, 12'h000, 32'h0000_0048);
    @(posedge clk);
    `CHK("b_super", 3'h7, {sm[1], waa[1], woa[1]})
  endtask
  // Sticky flags from events, then clearing and hit/miss recording
  task automatic t_flags;
    apb(1'h1, 12'h000, 32'h0000_0000);
    for (int k = 3; k < 8; k++) begin
      core.fire(k, 1'h1);
    end
    rdchk("flags", 32'h0038_0000, 32'h0034_0000);
    apb(1'h1, 12'h000, 32'h0010_0000);
    rdchk("clear", 32'h0000_0000, 32'h0030_0000);
    apb(1'h1, 12'h000, 32'h000C_0000);
    core.fire(6, 1'h0);
    core.fire(7, 1'h0);
    rdchk("hit", 32'h0004_0000, 32'h0020_0000);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly 130 cycles the run needs
  initial begin
    #80000;
    failures++;
    conclude;
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    t_reset;
    t_rw;
    t_unmapped;
    t_stack;
    t_irq;
    t_mode;
    t_flags;
    // Second reset in mid-run must restore the reset word
    @(posedge clk);
    arst_n <= 1'h0;
    @(posedge clk);
    arst_n <= 1'h1;
    t_reset;
    conclude;
  end
endmodule // test_processor_status_register
